/* rtl/slave_state_machine_defs.svh */
// Shared encodings, CRC constants and timing constants of the slave state machine
`ifndef SLAVE_STATE_MACHINE_DEFS_SVH
`define SLAVE_STATE_MACHINE_DEFS_SVH
`define REQ_POWER_ON        3'h1
`define REQ_MAILBOX_ONLY    3'h2
`define REQ_FW_UPDATE       3'h3
`define REQ_INPUTS_LIVE     3'h4
`define REQ_FULL_RUN        3'h5
`define ERR_NONE            4'h0
`define ERR_BAD_TRANSITION  4'h1
`define ERR_MAILBOX_CFG     4'h2
`define ERR_PD_CFG          4'h3
`define ERR_CLOCK_CFG       4'h4
`define ERR_BAD_REQUEST     4'h5
`define CLK_PERIOD_NS       100
`define NS_PER_TICK         `CLK_PERIOD_NS
`define CLOCK_TOL_NS        100
`define CRC32_POLY          32'h04c11db7
`define CRC32_INIT          32'hffffffff
`define CRC32_RESIDUE       32'hc704dd7b
`define FTM_PROTOCOL        4'h4
`endif

/* rtl/slave_state_machine_pkg.sv */
// Types shared by the slave state machine modules
package slave_state_machine_pkg;
  typedef enum logic [2:0] {
    power_on_state,
    mailbox_only_state,
    inputs_live_state,
    full_run_state,
    firmware_update_state
  } sm_state_t;
endpackage : slave_state_machine_pkg

/* rtl/frame_check_if.sv */
// Frame byte stream and check results between the state machine and the CRC checker
`timescale 1ns/1ns
interface frame_check_if;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       frame_end;
  logic       frame_done;
  logic       frame_ok;
  modport checker_side (input byte_valid, input byte_data, input frame_end, output frame_done, output frame_ok);
  modport user_side (output byte_valid, output byte_data, output frame_end, input frame_done, input frame_ok);
endinterface : frame_check_if

/* rtl/frame_crc_checker.sv */
// CRC-32 check of one received frame stream
`timescale 1ns/1ns
`include "slave_state_machine_defs.svh"
module frame_crc_checker
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  frame_check_if.checker_side fc
);
  logic [31:0] crc_reg;
  logic [31:0] crc_next;
  logic        done_reg;
  logic        ok_reg;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[31] ^ d[i])
        r = {r[30:0], 1'b0} ^ `CRC32_POLY;
      else
        r = {r[30:0], 1'b0};
    end
    return r;
  endfunction : crc_byte

  always_comb
  begin
    crc_next = fc.byte_valid ? crc_byte(crc_reg, fc.byte_data) : crc_reg;
  end

  // Frame's trailing CRC bytes are fed too, so a clean frame ends on the fixed residue
  always_ff @(posedge i_clk)
  begin
    if (i_rst || fc.frame_end)
      crc_reg <= `CRC32_INIT;
    else
      crc_reg <= crc_next;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      done_reg <= 1'b0;
      ok_reg   <= 1'b0;
    end
    else
    begin
      done_reg <= fc.frame_end;
      if (fc.frame_end)
        ok_reg <= (crc_next == `CRC32_RESIDUE);
    end
  end

  assign fc.frame_done = done_reg;
  assign fc.frame_ok   = ok_reg;
endmodule : frame_crc_checker

/* rtl/slave_state_machine.sv */
// Slave application-layer state machine with gating, local clock and error counters
// Function
// - Power-up enters power_on_state; no mailbox, no process data
// - Mailbox config checked before entering mailbox_only_state
// - mailbox_only_state: mailbox yes, process data no
// - Process channels and clock checked for inputs_live
// - Inputs copied to memory before inputs_live acknowledge; here the write and the acknowledge assert in the same cycle
// - inputs_live: both exchanges, inputs refresh, outputs safe; here outputs follow master data when i_watchdog_en is low
// - Watchdog forces safe outputs unless monitoring disabled; here only in inputs_live, full_run always drives master data
// - full_run: outputs follow master data, both exchanges
// - Firmware update entered only from power_on_state
// - Firmware update: only file transfer mailbox allowed
// - 64-bit nanosecond local clock, zero at 2000
// - Reduced build keeps only lower 32 clock bits
// - Clock corrections applied, deviation kept below 100 ns; here every correction is applied in full and o_clock_in_tol only flags one under 100 ns
// - Every frame checked by 32-bit CRC
// - Separate error counter per transmission segment
`timescale 1ns/1ns
`include "slave_state_machine_defs.svh"
module slave_state_machine
#(
  parameter int IO_W      = 16,
  parameter int CLOCK_W   = 64,
  parameter int SEGMENTS  = 2,
  parameter int ERR_CNT_W = 8
)
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_req_valid,
  input  wire logic [2:0]            i_req_state,
  input  wire logic                  i_mbx_cfg_ok,
  input  wire logic                  i_pd_cfg_ok,
  input  wire logic                  i_clock_used,
  input  wire logic                  i_clock_cfg_ok,
  input  wire logic                  i_mbx_req,
  input  wire logic [3:0]            i_mbx_protocol,
  input  wire logic                  i_pd_req,
  input  wire logic [IO_W-1:0]       i_inputs,
  input  wire logic [IO_W-1:0]       i_master_outputs,
  input  wire logic [IO_W-1:0]       i_safe_outputs,
  input  wire logic                  i_watchdog_en,
  input  wire logic                  i_clock_load,
  input  wire logic [CLOCK_W-1:0]    i_clock_load_value,
  input  wire logic                  i_clock_adj_valid,
  input  wire logic signed [15:0]    i_clock_adj_ns,
  input  wire logic                  i_byte_valid,
  input  wire logic [7:0]            i_byte_data,
  input  wire logic                  i_frame_end,
  input  wire logic [$clog2(SEGMENTS)-1:0] i_segment,
  input  wire logic                  i_err_clear,
  output logic [2:0]                 o_state,
  output logic                       o_req_ack,
  output logic                       o_req_err,
  output logic [3:0]                 o_err_code,
  output logic                       o_mbx_accept,
  output logic                       o_mbx_reject,
  output logic                       o_pd_accept,
  output logic                       o_pd_reject,
  output logic                       o_dpm_we,
  output logic [IO_W-1:0]            o_dpm_wdata,
  output logic [IO_W-1:0]            o_outputs,
  output logic [CLOCK_W-1:0]         o_local_time,
  output logic                       o_clock_in_tol,
  output logic                       o_frame_err,
  output logic [SEGMENTS*ERR_CNT_W-1:0] o_err_counts
);
  slave_state_machine_pkg::sm_state_t state_reg;
  slave_state_machine_pkg::sm_state_t state_next;
  logic                     ack_reg;
  logic                     err_reg;
  logic [3:0]               err_code_reg;
  logic [3:0]               err_code_next;
  logic                     go;
  logic                     dpm_we_reg;
  logic [IO_W-1:0]          dpm_wdata_reg;
  logic [IO_W-1:0]          outputs_reg;
  logic [CLOCK_W-1:0]       time_reg;
  logic                     tol_reg;
  logic                     frame_err_reg;
  logic [ERR_CNT_W-1:0]     err_cnt_reg [SEGMENTS];
  logic [$clog2(SEGMENTS)-1:0] seg_reg;
  // Sized once here so the signed compare below never depends on macro token pasting
  localparam logic signed [15:0] TOL_NS = 16'(`CLOCK_TOL_NS);

  frame_check_if fc ();
  assign fc.byte_valid = i_byte_valid;
  assign fc.byte_data  = i_byte_data;
  assign fc.frame_end  = i_frame_end;

  frame_crc_checker u_crc
  (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .fc    (fc)
  );

  // Transition checks; the state only moves when every check passes
  always_comb
  begin
    state_next    = state_reg;
    err_code_next = `ERR_NONE;
    go            = 1'b0;
    case (i_req_state)
      `REQ_POWER_ON:
        go = 1'b1;
      `REQ_MAILBOX_ONLY:
      begin
        if (state_reg == slave_state_machine_pkg::power_on_state)
        begin
          if (i_mbx_cfg_ok)
            go = 1'b1;
          else
            err_code_next = `ERR_MAILBOX_CFG;
        end
        else if (state_reg == slave_state_machine_pkg::inputs_live_state ||
                 state_reg == slave_state_machine_pkg::full_run_state ||
                 state_reg == slave_state_machine_pkg::mailbox_only_state)
          go = 1'b1;
        else
          err_code_next = `ERR_BAD_TRANSITION;
      end
      `REQ_FW_UPDATE:
      begin
        if (state_reg == slave_state_machine_pkg::power_on_state ||
            state_reg == slave_state_machine_pkg::firmware_update_state)
          go = 1'b1;
        else
          err_code_next = `ERR_BAD_TRANSITION;
      end
      `REQ_INPUTS_LIVE:
      begin
        if (state_reg == slave_state_machine_pkg::mailbox_only_state)
        begin
          if (!i_pd_cfg_ok)
            err_code_next = `ERR_PD_CFG;
          else if (i_clock_used && !i_clock_cfg_ok)
            err_code_next = `ERR_CLOCK_CFG;
          else
            go = 1'b1;
        end
        else if (state_reg == slave_state_machine_pkg::full_run_state ||
                 state_reg == slave_state_machine_pkg::inputs_live_state)
          go = 1'b1;
        else
          err_code_next = `ERR_BAD_TRANSITION;
      end
      `REQ_FULL_RUN:
      begin
        if (state_reg == slave_state_machine_pkg::inputs_live_state ||
            state_reg == slave_state_machine_pkg::full_run_state)
          go = 1'b1;
        else
          err_code_next = `ERR_BAD_TRANSITION;
      end
      default:
        err_code_next = `ERR_BAD_REQUEST;
    endcase
    if (go)
    begin
      case (i_req_state)
        `REQ_POWER_ON:     state_next = slave_state_machine_pkg::power_on_state;
        `REQ_MAILBOX_ONLY: state_next = slave_state_machine_pkg::mailbox_only_state;
        `REQ_FW_UPDATE:    state_next = slave_state_machine_pkg::firmware_update_state;
        `REQ_INPUTS_LIVE:  state_next = slave_state_machine_pkg::inputs_live_state;
        `REQ_FULL_RUN:     state_next = slave_state_machine_pkg::full_run_state;
        default:           state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_reg <= slave_state_machine_pkg::power_on_state;
    else if (i_req_valid && go)
      state_reg <= state_next;
  end

  // Error flag holds until the next accepted request so the master can read it
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ack_reg      <= 1'b0;
      err_reg      <= 1'b0;
      err_code_reg <= `ERR_NONE;
    end
    else
    begin
      ack_reg <= i_req_valid && go;
      if (i_req_valid && !go)
      begin
        err_reg      <= 1'b1;
        err_code_reg <= err_code_next;
      end
      else if (i_req_valid)
      begin
        err_reg      <= 1'b0;
        err_code_reg <= `ERR_NONE;
      end
    end
  end

  // Input snapshot written in the accepting cycle, so it appears in the same cycle as the acknowledge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dpm_we_reg    <= 1'b0;
      dpm_wdata_reg <= '0;
    end
    else
    begin
      dpm_we_reg <= (i_req_valid && go && i_req_state == `REQ_INPUTS_LIVE) ||
                    state_reg == slave_state_machine_pkg::inputs_live_state ||
                    state_reg == slave_state_machine_pkg::full_run_state;
      dpm_wdata_reg <= i_inputs;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      outputs_reg <= '0;
    else
    begin
      case (state_reg)
        slave_state_machine_pkg::full_run_state:
          outputs_reg <= i_master_outputs;
        slave_state_machine_pkg::inputs_live_state:
          outputs_reg <= i_watchdog_en ? i_safe_outputs : i_master_outputs;
        default:
          outputs_reg <= i_safe_outputs;
      endcase
    end
  end

  // Traffic gating per state
  always_comb
  begin
    o_mbx_accept = 1'b0;
    o_pd_accept  = 1'b0;
    case (state_reg)
      slave_state_machine_pkg::power_on_state:
      begin
        o_mbx_accept = 1'b0;
        o_pd_accept  = 1'b0;
      end
      slave_state_machine_pkg::mailbox_only_state:
        o_mbx_accept = i_mbx_req;
      slave_state_machine_pkg::inputs_live_state,
      slave_state_machine_pkg::full_run_state:
      begin
        o_mbx_accept = i_mbx_req;
        o_pd_accept  = i_pd_req;
      end
      slave_state_machine_pkg::firmware_update_state:
        o_mbx_accept = i_mbx_req && i_mbx_protocol == `FTM_PROTOCOL;
      default:
      begin
        o_mbx_accept = 1'b0;
        o_pd_accept  = 1'b0;
      end
    endcase
    o_mbx_reject = i_mbx_req && !o_mbx_accept;
    o_pd_reject  = i_pd_req && !o_pd_accept;
  end

  // Local clock: a 32-bit build simply wraps after about 4.3 s
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      time_reg <= '0;
    else if (i_clock_load)
      time_reg <= i_clock_load_value;
    else if (i_clock_adj_valid)
      time_reg <= time_reg + CLOCK_W'(`NS_PER_TICK) + CLOCK_W'(i_clock_adj_ns);
    else
      time_reg <= time_reg + CLOCK_W'(`NS_PER_TICK);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      tol_reg <= 1'b0;
    else if (i_clock_adj_valid)
      tol_reg <= (i_clock_adj_ns < TOL_NS) && (i_clock_adj_ns > -TOL_NS);
  end

  // Counters saturate so a degraded segment never looks healthy after a wrap
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      seg_reg       <= '0;
      frame_err_reg <= 1'b0;
      for (int s = 0; s < SEGMENTS; s++)
        err_cnt_reg[s] <= '0;
    end
    else
    begin
      if (i_frame_end)
        seg_reg <= i_segment;
      frame_err_reg <= fc.frame_done && !fc.frame_ok;
      for (int s = 0; s < SEGMENTS; s++)
      begin
        if (fc.frame_done && !fc.frame_ok && seg_reg == s[$clog2(SEGMENTS)-1:0] &&
            err_cnt_reg[s] != '1)
          err_cnt_reg[s] <= err_cnt_reg[s] + 1'b1;
        else if (i_err_clear)
          err_cnt_reg[s] <= '0;
      end
    end
  end

  always_comb
  begin
    for (int s = 0; s < SEGMENTS; s++)
      o_err_counts[s*ERR_CNT_W +: ERR_CNT_W] = err_cnt_reg[s];
  end

  assign o_state        = state_reg;
  assign o_req_ack      = ack_reg;
  assign o_req_err      = err_reg;
  assign o_err_code     = err_code_reg;
  assign o_dpm_we       = dpm_we_reg;
  assign o_dpm_wdata    = dpm_wdata_reg;
  assign o_outputs      = outputs_reg;
  assign o_local_time   = time_reg;
  assign o_clock_in_tol = tol_reg;
  assign o_frame_err    = frame_err_reg;
endmodule : slave_state_machine

/* test/slave_state_machine_assertions.sv */
// Port-level checker for the slave state machine
`timescale 1ns/1ns
`include "slave_state_machine_defs.svh"
module slave_state_machine_assertions
#(
  parameter int IO_W    = 16,
  parameter int CLOCK_W = 64
)
(
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic               i_req_valid,
  input wire logic [2:0]         i_req_state,
  input wire logic               i_mbx_cfg_ok,
  input wire logic               i_pd_cfg_ok,
  input wire logic               i_clock_used,
  input wire logic               i_clock_cfg_ok,
  input wire logic               i_mbx_req,
  input wire logic [3:0]         i_mbx_protocol,
  input wire logic [IO_W-1:0]    i_inputs,
  input wire logic [IO_W-1:0]    i_master_outputs,
  input wire logic [IO_W-1:0]    i_safe_outputs,
  input wire logic               i_watchdog_en,
  input wire logic               i_clock_load,
  input wire logic               i_clock_adj_valid,
  input wire logic [2:0]         o_state,
  input wire logic               o_req_err,
  input wire logic [3:0]         o_err_code,
  input wire logic               o_mbx_accept,
  input wire logic               o_pd_accept,
  input wire logic               o_dpm_we,
  input wire logic [IO_W-1:0]    o_dpm_wdata,
  input wire logic [IO_W-1:0]    o_outputs,
  input wire logic [CLOCK_W-1:0] o_local_time
);
  logic req_mbx;
  logic req_live;
  logic req_fw;
  logic live_ok;
  assign req_mbx  = i_req_valid && i_req_state == `REQ_MAILBOX_ONLY;
  assign req_live = i_req_valid && i_req_state == `REQ_INPUTS_LIVE;
  assign req_fw   = i_req_valid && i_req_state == `REQ_FW_UPDATE;
  assign live_ok  = i_pd_cfg_ok && (!i_clock_used || i_clock_cfg_ok);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  AST_PWR_NO_XCHG: assert property (o_state == 3'h0 |-> !o_mbx_accept && !o_pd_accept)
    else $error("exchange accepted in power-on state");
  AST_MBX_CFG: assert property (o_state == 3'h0 && req_mbx && !i_mbx_cfg_ok |=> o_state == 3'h0 && o_req_err)
    else $error("bad mailbox setup not refused");
  AST_PD_CFG: assert property (o_state == 3'h1 && req_live && !i_pd_cfg_ok |=> o_err_code == `ERR_PD_CFG)
    else $error("bad process channel setup not refused");
  AST_DPM_SNAP: assert property (o_state == 3'h1 && req_live && live_ok |=> o_state == 3'h2 && o_dpm_we)
    else $error("entry to inputs-live without input snapshot");
  AST_REFRESH: assert property (o_state inside {3'h2, 3'h3} |=> o_dpm_we && o_dpm_wdata == $past(i_inputs))
    else $error("inputs not refreshed into memory");
  AST_SAFE_OUT: assert property (!$past(i_rst) && $past(o_state) == 3'h2 && $past(i_watchdog_en)
    |-> o_outputs == $past(i_safe_outputs))
    else $error("outputs not safe in inputs-live state");
  AST_RUN_OUT: assert property (!$past(i_rst) && $past(o_state) == 3'h3 && !$past(i_watchdog_en)
    |-> o_outputs == $past(i_master_outputs))
    else $error("outputs do not follow master data");
  AST_FW_ONLY_PWR: assert property (req_fw && o_state inside {3'h1, 3'h2, 3'h3}
    |=> $stable(o_state) && o_req_err)
    else $error("firmware update entered from a running state");
  AST_FW_MBX: assert property (o_state == 3'h4
    |-> !o_pd_accept && o_mbx_accept == (i_mbx_req && i_mbx_protocol == `FTM_PROTOCOL))
    else $error("wrong exchange served during firmware update");
  AST_TIME: assert property (!$past(i_rst) && !$past(i_clock_load) && !$past(i_clock_load, 2)
    && !$past(i_clock_adj_valid) && !$past(i_clock_adj_valid, 2) |-> o_local_time == $past(o_local_time) + 64'h64)
    else $error("local time did not advance by one clock period");
  COV_RUN: cover property (o_state == 3'h3);
  COV_FW: cover property (o_state == 3'h4);
  COV_CLK_ERR: cover property (o_req_err && o_err_code == `ERR_CLOCK_CFG);
endmodule : slave_state_machine_assertions

bind slave_state_machine slave_state_machine_assertions #(.IO_W(IO_W), .CLOCK_W(CLOCK_W))
  u_slave_state_machine_assertions
(
  .i_clk, .i_rst, .i_req_valid, .i_req_state, .i_mbx_cfg_ok, .i_pd_cfg_ok, .i_clock_used, .i_clock_cfg_ok,
  .i_mbx_req, .i_mbx_protocol, .i_inputs, .i_master_outputs, .i_safe_outputs, .i_watchdog_en, .i_clock_load,
  .i_clock_adj_valid, .o_state, .o_req_err, .o_err_code, .o_mbx_accept, .o_pd_accept, .o_dpm_we, .o_dpm_wdata,
  .o_outputs, .o_local_time
);

/* test/master_model.sv */
// Behavioural network master: channel setup, output data and state requests
`timescale 1ns/1ns
module master_model
(
  input  wire logic i_clk,
  output logic      o_req_valid,
  output logic [2:0]  o_req_state,
  output logic      o_mbx_cfg_ok,
  output logic      o_pd_cfg_ok,
  output logic [15:0] o_master_outputs
);
  initial
  begin
    o_req_valid = 1'b0;
    o_req_state = 3'h0;
    o_mbx_cfg_ok = 1'b0;
    o_pd_cfg_ok = 1'b0;
    o_master_outputs = 16'h0000;
  end
  // A level stands for a finished setup; a scenario may leave it wrong on purpose
  task automatic configure(input logic mbx, input logic pd);
    o_mbx_cfg_ok = mbx;
    o_pd_cfg_ok = pd;
  endtask : configure
  task automatic load_outputs(input logic [15:0] value);
    o_master_outputs = value;
  endtask : load_outputs
  // Held over exactly one taking edge, then released
  task automatic request(input logic [2:0] target);
    @(posedge i_clk);
    #1 o_req_state = target;
    o_req_valid = 1'b1;
    @(posedge i_clk);
    #1 o_req_valid = 1'b0;
  endtask : request
endmodule : master_model

/* test/test_slave_state_machine.sv */
// Self-checking bench for the slave state machine
`timescale 1ns/1ns
`include "slave_state_machine_defs.svh"
module test_slave_state_machine;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_clock_used = 1'b0, i_clock_cfg_ok = 1'b1, i_mbx_req = 1'b0, i_pd_req = 1'b0, i_watchdog_en = 1'b1;
  logic        i_clock_load = 1'b0, i_clock_adj_valid = 1'b0, i_byte_valid = 1'b0, i_frame_end = 1'b0;
  logic        i_segment = 1'b0, i_err_clear = 1'b0;
  logic [3:0]  i_mbx_protocol = 4'h0;
  logic [15:0] i_inputs = 16'h1234, i_safe_outputs = 16'h0f0f;
  logic [63:0] i_clock_load_value = 64'h0;
  logic [7:0]  i_byte_data = 8'h00;
  logic signed [15:0] i_clock_adj_ns = 16'sh0;
  wire         i_req_valid, i_mbx_cfg_ok, i_pd_cfg_ok, o_req_ack, o_req_err, o_mbx_accept, o_mbx_reject;
  wire         o_pd_accept, o_pd_reject, o_dpm_we, o_clock_in_tol, o_frame_err;
  wire [2:0]   i_req_state, o_state;
  wire [3:0]   o_err_code;
  wire [15:0]  i_master_outputs, o_dpm_wdata, o_outputs, o_err_counts;
  wire [63:0]  o_local_time;
  logic [63:0] t0;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;

  slave_state_machine u_slave_state_machine
  (
    .i_clk, .i_rst, .i_req_valid, .i_req_state, .i_mbx_cfg_ok, .i_pd_cfg_ok, .i_clock_used, .i_clock_cfg_ok,
    .i_mbx_req, .i_mbx_protocol, .i_pd_req, .i_inputs, .i_master_outputs, .i_safe_outputs, .i_watchdog_en,
    .i_clock_load, .i_clock_load_value, .i_clock_adj_valid, .i_clock_adj_ns, .i_byte_valid, .i_byte_data,
    .i_frame_end, .i_segment, .i_err_clear, .o_state, .o_req_ack, .o_req_err, .o_err_code, .o_mbx_accept,
    .o_mbx_reject, .o_pd_accept, .o_pd_reject, .o_dpm_we, .o_dpm_wdata, .o_outputs, .o_local_time,
    .o_clock_in_tol, .o_frame_err, .o_err_counts
  );
  master_model u_master_model
  (
    .i_clk, .o_req_valid(i_req_valid), .o_req_state(i_req_state), .o_mbx_cfg_ok(i_mbx_cfg_ok),
    .o_pd_cfg_ok(i_pd_cfg_ok), .o_master_outputs(i_master_outputs)
  );

  always #50 i_clk = ~i_clk;

  // Generous ceiling: the whole sequence needs well under 200 cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic check(input string name, input logic [63:0] expected, input logic [63:0] seen);
    total_checks++;
    if (seen !== expected)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, expected, seen);
    end
  endtask : check

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick

  task automatic t_power_on();
    i_mbx_req = 1'b1;
    i_pd_req = 1'b1;
    tick();
    check("state", 64'h0, o_state);
    check("mbx_accept", 64'h0, o_mbx_accept);
    check("pd_accept", 64'h0, o_pd_accept);
    u_master_model.request(3'h7);
    check("state", 64'h0, o_state);
    check("err_code", `ERR_BAD_REQUEST, o_err_code);
  endtask : t_power_on

  task automatic t_firmware();
    u_master_model.request(`REQ_FW_UPDATE);
    check("state", 64'h4, o_state);
    i_pd_req = 1'b1;
    i_mbx_protocol = `FTM_PROTOCOL;
    tick();
    check("mbx_accept", 64'h1, o_mbx_accept);
    check("pd_accept", 64'h0, o_pd_accept);
    i_mbx_protocol = 4'h3;
    tick();
    check("mbx_reject", 64'h1, o_mbx_reject);
    u_master_model.request(`REQ_POWER_ON);
    check("state", 64'h0, o_state);
  endtask : t_firmware

  task automatic t_mailbox();
    u_master_model.configure(1'b0, 1'b0);
    u_master_model.request(`REQ_MAILBOX_ONLY);
    check("state", 64'h0, o_state);
    check("req_err", 64'h1, o_req_err);
    check("err_code", `ERR_MAILBOX_CFG, o_err_code);
    u_master_model.configure(1'b1, 1'b0);
    u_master_model.request(`REQ_MAILBOX_ONLY);
    check("state", 64'h1, o_state);
    check("req_ack", 64'h1, o_req_ack);
    check("mbx_accept", 64'h1, o_mbx_accept);
    check("pd_reject", 64'h1, o_pd_reject);
    u_master_model.request(`REQ_FW_UPDATE);
    check("state", 64'h1, o_state);
    check("err_code", `ERR_BAD_TRANSITION, o_err_code);
  endtask : t_mailbox

  task automatic t_inputs_live();
    u_master_model.request(`REQ_INPUTS_LIVE);
    check("err_code", `ERR_PD_CFG, o_err_code);
    u_master_model.configure(1'b1, 1'b1);
    i_clock_used = 1'b1;
    i_clock_cfg_ok = 1'b0;
    u_master_model.request(`REQ_INPUTS_LIVE);
    check("err_code", `ERR_CLOCK_CFG, o_err_code);
    check("state", 64'h1, o_state);
    i_clock_cfg_ok = 1'b1;
    i_inputs = 16'ha5c3;
    u_master_model.request(`REQ_INPUTS_LIVE);
    check("state", 64'h2, o_state);
    check("dpm_we", 64'h1, o_dpm_we);
    check("dpm_wdata", 64'ha5c3, o_dpm_wdata);
    i_inputs = 16'h5a3c;
    tick();
    check("outputs", 64'h0f0f, o_outputs);
    check("pd_accept", 64'h1, o_pd_accept);
    check("dpm_wdata", 64'h5a3c, o_dpm_wdata);
  endtask : t_inputs_live

  task automatic t_full_run();
    u_master_model.load_outputs(16'hbeef);
    i_watchdog_en = 1'b0;
    u_master_model.request(`REQ_FULL_RUN);
    check("state", 64'h3, o_state);
    tick();
    check("outputs", 64'hbeef, o_outputs);
    check("mbx_accept", 64'h1, o_mbx_accept);
    check("pd_accept", 64'h1, o_pd_accept);
    u_master_model.load_outputs(16'h1357);
    tick();
    tick();
    check("outputs", 64'h1357, o_outputs);
  endtask : t_full_run

  task automatic t_clock();
    i_clock_load_value = 64'h0000_0001_ffff_ff00;
    i_clock_load = 1'b1;
    tick();
    i_clock_load = 1'b0;
    repeat (3) tick();
    check("time_high", 64'h2, o_local_time[63:32]);
    t0 = o_local_time;
    i_clock_adj_ns = 16'sh28;
    i_clock_adj_valid = 1'b1;
    tick();
    i_clock_adj_valid = 1'b0;
    repeat (4) tick();
    check("time_adjusted", t0 + 64'h21c, o_local_time);
    check("in_tol", 64'h1, o_clock_in_tol);
    i_clock_adj_ns = 16'sh12c;
    i_clock_adj_valid = 1'b1;
    tick();
    i_clock_adj_valid = 1'b0;
    repeat (4) tick();
    check("in_tol", 64'h0, o_clock_in_tol);
  endtask : t_clock

  task automatic t_crc();
    i_segment = 1'b1;
    for (int k = 1; k <= 5; k++)
    begin
      i_byte_valid = 1'b1;
      i_byte_data = 8'(k);
      i_frame_end = (k == 5);
      tick();
    end
    i_byte_valid = 1'b0;
    i_frame_end = 1'b0;
    tick();
    check("frame_err", 64'h1, o_frame_err);
    repeat (3) tick();
    check("frame_err", 64'h0, o_frame_err);
    check("err_counts", 64'h0100, o_err_counts);
    i_err_clear = 1'b1;
    tick();
    i_err_clear = 1'b0;
    tick();
    check("err_counts", 64'h0000, o_err_counts);
  endtask : t_crc

  initial
  begin
    repeat (10) @(posedge i_clk);
    #1 i_rst = 1'b0;
    t_power_on();
    t_firmware();
    t_mailbox();
    t_inputs_live();
    t_full_run();
    t_clock();
    t_crc();
    results();
  end
endmodule : test_slave_state_machine
